// ==== hw/cch_pkg.sv ====
// Purpose: Constants for the continuous carrier command handler
// Assumes: 250 MHz ref_clk, commands pre-decoded from the burst time plan table
// Notes on behaviour
// [R1] Carrier commands arrive only via plan table
// [R2] Assignment answered by acknowledgement element, then traffic
// [R3] No transmit before assigned slot start time
// [R4] Combined-mode terminal keeps slotted access running
// [R5] Otherwise send logoff, then stop slotted access
// [R6] Release stops carrier within two seconds
// [R7] Permanent assign: assign plus persistent start flag
// [R8] Permanent release: release plus clear persistent flag
// [R9] Element type codes are fixed eight-bit values
// [R10] Acknowledgement carries accept bit and slot identity
// [R11] Persistent flag and identity survive reinitialisation
package cch_pkg;
  localparam logic [7:0] CCH_MT_ASSIGN = 8'h00;
  localparam logic [7:0] CCH_MT_RELEASE = 8'h01;
  localparam logic [7:0] CCH_MT_REPLACE = 8'h02;
  localparam logic [7:0] CCH_MT_PERM_ASSIGN = 8'h03;
  localparam logic [7:0] CCH_MT_PERM_RELEASE = 8'h04;
  localparam logic [7:0] CCH_MT_ACK = 8'h05;
  localparam logic [7:0] CCH_MT_USER_BASE = 8'h80;
  localparam int CCH_SF_W = 8;
  localparam int CCH_FR_W = 5;
  localparam int CCH_TS_W = 11;
  localparam int CCH_ID_W = CCH_SF_W + CCH_FR_W + CCH_TS_W;
  localparam longint CCH_CLK_HZ = 250000000;
  localparam longint CCH_RELEASE_MS = 2000;
  localparam longint CCH_RELEASE_CYC = CCH_CLK_HZ / 1000 * CCH_RELEASE_MS;
  localparam logic CCH_ACCEPT = 1'b1;
  localparam logic CCH_PERM_RST = 1'b0;
  typedef enum logic [3:0] {
    CCH_IDLE = 4'h1,
    CCH_ACK = 4'h2,
    CCH_LOGOFF = 4'h4,
    CCH_ACTIVE = 4'h8
  } cch_state_e;
endpackage

// ==== hw/cch_cmd_if.sv ====
`timescale 1ns/10ps
`default_nettype none
// Purpose: Decoded command bundle between decoder and handler core
// Assumes: One-cycle command pulses
// Notes: Type fields per fixed code table
interface cch_cmd_if;
  logic assign_p;
  logic release_p;
  logic permanent;
  logic [cch_pkg::CCH_ID_W-1:0] slot_id;
  modport src (output assign_p, output release_p, output permanent, output slot_id);
  modport dst (input assign_p, input release_p, input permanent, input slot_id);
endinterface
`default_nettype wire

// ==== hw/cch_decode.sv ====
`timescale 1ns/10ps
`default_nettype none
// Purpose: Decodes carrier element type from plan table into commands
// Assumes: cmd_valid is a one-cycle pulse from the plan table parser
// Notes: Replacement, reserved and user codes are ignored here
module cch_decode (
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_type,
  input wire logic [cch_pkg::CCH_ID_W-1:0] cmd_slot,
  cch_cmd_if.src cmd
);
  wire is_asg = cmd_type == cch_pkg::CCH_MT_ASSIGN; // [R9]
  wire is_pasg = cmd_type == cch_pkg::CCH_MT_PERM_ASSIGN; // [R9]
  wire is_rel = cmd_type == cch_pkg::CCH_MT_RELEASE; // [R9]
  wire is_prel = cmd_type == cch_pkg::CCH_MT_PERM_RELEASE; // [R9]
  assign cmd.assign_p = cmd_valid & (is_asg | is_pasg); // [R1] [R7]
  assign cmd.release_p = cmd_valid & (is_rel | is_prel); // [R1] [R8]
  assign cmd.permanent = is_pasg | is_prel;
  assign cmd.slot_id = cmd_slot;
endmodule
`default_nettype wire

// ==== hw/cch_handler.sv ====
`timescale 1ns/10ps
`default_nettype none
// Purpose: Continuous carrier command handler of the return channel terminal
// Assumes: Table commands, slot start strobe and capability inputs are synchronous
// Notes: Persistent flag reset by rst_n power-on or a permanent release; soft reinit keeps it
module cch_handler #(
  parameter longint RELEASE_CYC = cch_pkg::CCH_RELEASE_CYC,
  parameter bit COMBINED_MODE = 1'b0
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_type,
  input wire logic [cch_pkg::CCH_ID_W-1:0] cmd_slot,
  input wire logic carrier_capable,
  input wire logic slot_start,
  input wire logic [cch_pkg::CCH_ID_W-1:0] cur_slot,
  input wire logic ack_ready,
  input wire logic logoff_ready,
  output logic ack_valid,
  output logic [7:0] ack_type,
  output logic ack_accept,
  output logic [cch_pkg::CCH_ID_W-1:0] ack_slot,
  output logic logoff_req,
  output logic access_enable,
  output logic carrier_tx_en,
  output logic perm_carrier,
  output logic [cch_pkg::CCH_ID_W-1:0] perm_slot
);
  initial begin
    if (RELEASE_CYC < 2) $error("RELEASE_CYC too small");
    // Timer is 40 bits wide; longer deadlines would wrap silently
    if (RELEASE_CYC > 64'h0000_00ff_ffff_ffff) $error("RELEASE_CYC exceeds timer width");
  end
  cch_cmd_if cmd ();
  cch_decode u_dec (
    .cmd_valid(cmd_valid),
    .cmd_type(cmd_type),
    .cmd_slot(cmd_slot),
    .cmd(cmd)
  );
  cch_pkg::cch_state_e state_reg, state_next;
  logic [cch_pkg::CCH_ID_W-1:0] slot_reg;
  logic [39:0] rel_cnt_reg;
  logic rel_pend_reg;
  logic started_reg;
  wire ack_done = ack_valid & ack_ready;
  wire logoff_done = logoff_req & logoff_ready;
  wire slot_hit = slot_start & (cur_slot == slot_reg);
  wire rel_expire = rel_pend_reg & (rel_cnt_reg == 40'h0);
  wire rel_cut = rel_pend_reg & (rel_expire | slot_start);
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      cch_pkg::CCH_IDLE: begin
        if (cmd.assign_p) state_next = cch_pkg::CCH_ACK; // [R2]
      end
      cch_pkg::CCH_ACK: begin
        if (ack_done && !carrier_capable) state_next = cch_pkg::CCH_IDLE;
        else if (ack_done && COMBINED_MODE) state_next = cch_pkg::CCH_ACTIVE; // [R4]
        else if (ack_done) state_next = cch_pkg::CCH_LOGOFF; // [R5]
      end
      cch_pkg::CCH_LOGOFF: begin
        if (logoff_done) state_next = cch_pkg::CCH_ACTIVE; // [R5]
      end
      cch_pkg::CCH_ACTIVE: begin
        if (rel_cut) state_next = cch_pkg::CCH_IDLE; // [R6]
      end
      default: state_next = cch_pkg::CCH_IDLE;
    endcase
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= cch_pkg::CCH_IDLE;
      slot_reg <= '0;
      ack_valid <= 1'b0;
      ack_type <= cch_pkg::CCH_MT_ACK;
      ack_accept <= 1'b0;
      ack_slot <= '0;
    end else begin
      state_reg <= state_next;
      if (state_reg == cch_pkg::CCH_IDLE && cmd.assign_p) begin
        slot_reg <= cmd.slot_id;
        ack_valid <= 1'b1; // [R2]
        ack_accept <= carrier_capable ? cch_pkg::CCH_ACCEPT : ~cch_pkg::CCH_ACCEPT; // [R10]
        ack_slot <= cmd.slot_id; // [R10]
      end else if (ack_done) begin
        ack_valid <= 1'b0;
      end
    end
  end
  // Release timer starts when the release command arrives in the active state
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rel_pend_reg <= 1'b0;
      rel_cnt_reg <= '0;
    end else if (cmd.release_p && state_reg == cch_pkg::CCH_ACTIVE) begin
      rel_pend_reg <= 1'b1;
      rel_cnt_reg <= 40'(RELEASE_CYC - 2); // [R6]
    end else if (rel_cut || state_reg != cch_pkg::CCH_ACTIVE) begin
      rel_pend_reg <= 1'b0;
    end else if (rel_pend_reg) begin
      rel_cnt_reg <= rel_cnt_reg - 40'h1;
    end
  end
  // Hold transmit until the assigned slot begins
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      started_reg <= 1'b0;
      carrier_tx_en <= 1'b0;
      logoff_req <= 1'b0;
      access_enable <= 1'b1;
    end else begin
      if (state_next != cch_pkg::CCH_ACTIVE) started_reg <= 1'b0;
      else if (slot_hit) started_reg <= 1'b1; // [R3]
      carrier_tx_en <= (state_next == cch_pkg::CCH_ACTIVE) & (started_reg | slot_hit); // [R3]
      logoff_req <= state_next == cch_pkg::CCH_LOGOFF; // [R5]
      if (state_next == cch_pkg::CCH_IDLE) access_enable <= 1'b1;
      else if (state_reg == cch_pkg::CCH_LOGOFF && logoff_done) access_enable <= 1'b0; // [R5]
    end
  end
  // Persistent condition: soft reinit must not clear it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      perm_carrier <= cch_pkg::CCH_PERM_RST;
      perm_slot <= '0;
    end else if (cmd.assign_p && cmd.permanent && state_reg == cch_pkg::CCH_IDLE
                 && carrier_capable) begin
      perm_carrier <= 1'b1; // [R7] [R11]
      perm_slot <= cmd.slot_id; // [R11]
    end else if (cmd.release_p && cmd.permanent) begin
      perm_carrier <= 1'b0; // [R8]
    end
  end
  a_tx_waits_slot: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(carrier_tx_en) |-> $past(slot_hit) || $past(started_reg)) // [R3]
    else $error("transmit began before slot start");
  a_ack_after_assign: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_reg == cch_pkg::CCH_IDLE && cmd.assign_p) |=> ack_valid && ack_slot == $past(cmd_slot)) // [R2]
    else $error("assignment not acknowledged");
  a_ack_code: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ack_valid |-> ack_type == 8'h05) // [R9]
    else $error("wrong acknowledgement code");
  a_ack_accept_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_reg == cch_pkg::CCH_IDLE && cmd.assign_p) |=> ack_accept == $past(carrier_capable)) // [R10]
    else $error("accept flag mismatch");
  a_logoff_first: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $fell(access_enable) |-> $past(logoff_req) && !COMBINED_MODE) // [R5]
    else $error("slotted access dropped without logoff");
  a_combined_keeps: assert property (@(posedge ref_clk) disable iff (!rst_n)
    COMBINED_MODE |-> access_enable) // [R4]
    else $error("combined mode lost slotted access");
  a_release_slot_cut: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (rel_pend_reg && slot_start && state_reg == cch_pkg::CCH_ACTIVE) |=> ##1 !carrier_tx_en) // [R6]
    else $error("carrier not ceased after release");
  a_perm_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (cmd.assign_p && cmd.permanent && state_reg == cch_pkg::CCH_IDLE && carrier_capable)
    |=> perm_carrier && perm_slot == $past(cmd_slot)) // [R7]
    else $error("permanent flag not set");
  a_perm_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (cmd.release_p && cmd.permanent && !(cmd.assign_p)) |=> !perm_carrier) // [R8]
    else $error("permanent flag not cleared");
  // Age of a pending release; bounds the cut without a long repetition
  logic [39:0] rel_age_reg;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rel_age_reg <= '0;
    end else if (!rel_pend_reg || cmd.release_p) begin
      rel_age_reg <= '0;
    end else begin
      rel_age_reg <= rel_age_reg + 40'h1;
    end
  end
  sequence s_ack_stall;
    ack_valid && !ack_ready;
  endsequence
  sequence s_logoff_stall;
    logoff_req && !logoff_ready;
  endsequence
  sequence s_rel_armed;
    rel_pend_reg && state_reg == cch_pkg::CCH_ACTIVE;
  endsequence
  a_ack_holds: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R2]
    s_ack_stall |=> ack_valid && $stable(ack_slot) && $stable(ack_accept))
    else $error("acknowledgement changed while stalled");
  a_ack_source: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R2]
    $rose(ack_valid) |-> $past(cmd.assign_p))
    else $error("acknowledgement without assignment");
  a_logoff_holds: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R5]
    s_logoff_stall |=> logoff_req)
    else $error("logoff dropped before taken");
  a_logoff_mode: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R4]
    logoff_req |-> !COMBINED_MODE)
    else $error("logoff in combined mode");
  a_tx_only_active: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R3]
    carrier_tx_en |-> state_reg == cch_pkg::CCH_ACTIVE)
    else $error("transmit outside active state");
  a_release_deadline: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R6]
    s_rel_armed |-> rel_age_reg < 40'(RELEASE_CYC))
    else $error("release pending too long");
  a_release_expire: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R6]
    (s_rel_armed ##0 rel_cnt_reg == 40'h0) |=> !carrier_tx_en)
    else $error("carrier kept after release timeout");
  a_idle_access: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R5]
    state_reg == cch_pkg::CCH_IDLE |-> access_enable && !carrier_tx_en)
    else $error("idle state without slotted access");
  a_perm_refused: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R7]
    (cmd.assign_p && cmd.permanent && !carrier_capable && !perm_carrier) |=> !perm_carrier)
    else $error("permanent flag set on rejection");
  a_ack_slot_kept: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R10]
    state_reg == cch_pkg::CCH_ACTIVE |-> slot_reg == ack_slot)
    else $error("active carrier differs from acknowledged");
endmodule
`default_nettype wire

// ==== dv/cch_centre_model.sv ====
// Purpose: Control centre model issuing carrier commands and slot strobes
// Assumes: Bench calls the tasks; lines change at the falling edge
// Notes: Lines are inverted after each pulse so stale values never match
`timescale 1ns/10ps
`default_nettype none
module cch_centre_model (
  input wire logic ref_clk,
  output logic cmd_valid,
  output logic [7:0] cmd_type,
  output logic [cch_pkg::CCH_ID_W-1:0] cmd_slot,
  output logic slot_start,
  output logic [cch_pkg::CCH_ID_W-1:0] cur_slot
);
  initial begin
    cmd_valid = 1'b0;
    cmd_type = 8'h5a;
    cmd_slot = '0;
    slot_start = 1'b0;
    cur_slot = '1;
  end
  // Commands only travel as plan table elements, one cycle each
  task automatic send(input logic [7:0] t, input logic [cch_pkg::CCH_ID_W-1:0] s);
    @(negedge ref_clk);
    cmd_valid = 1'b1;
    cmd_type = t;
    cmd_slot = s;
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    cmd_type = ~t;
    cmd_slot = ~s;
  endtask
  task automatic slot(input logic [cch_pkg::CCH_ID_W-1:0] s);
    @(negedge ref_clk);
    slot_start = 1'b1;
    cur_slot = s;
    @(negedge ref_clk);
    slot_start = 1'b0;
    cur_slot = ~s;
  endtask
endmodule
`default_nettype wire

// ==== dv/cch_handler_test.sv ====
// Purpose: Self-checking bench for the carrier command handler
// Assumes: Non-combined terminal, release timeout shortened to 20 cycles
// Notes: Handshake readies are random, so acks and logoffs see stalls
`timescale 1ns/10ps
`default_nettype none
module cch_handler_test;
  localparam int RC = 20;
  localparam int W = cch_pkg::CCH_ID_W;
  logic ref_clk = 1'b0, rst_n = 1'b0, carrier_capable = 1'b1;
  logic ack_ready = 1'b0, logoff_ready = 1'b0, cmd_valid, slot_start;
  logic ack_valid, ack_accept, logoff_req, access_enable, carrier_tx_en, perm_carrier;
  logic [7:0] cmd_type, ack_type;
  logic [W-1:0] cmd_slot, cur_slot, ack_slot, perm_slot;
  int num_errors = 0, tests_run = 0, k = 0;
  integer seed = 32'hde62641b;
  logic [32:0] exp_q[$];
  logic [7:0] codes [8] = '{8'h02, 8'h05, 8'h06, 8'h7f, 8'h80, 8'hff, 8'h01, 8'h04};
  always #2 ref_clk = ~ref_clk;
  always @(negedge ref_clk) {ack_ready, logoff_ready} <= 2'($random(seed));
  cch_centre_model u_cch_centre_model (.ref_clk(ref_clk), .cmd_valid(cmd_valid),
    .cmd_type(cmd_type), .cmd_slot(cmd_slot), .slot_start(slot_start), .cur_slot(cur_slot));
  cch_handler #(.RELEASE_CYC(RC), .COMBINED_MODE(1'b0)) u_cch_handler (.ref_clk(ref_clk),
    .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_type(cmd_type), .cmd_slot(cmd_slot),
    .carrier_capable(carrier_capable), .slot_start(slot_start), .cur_slot(cur_slot),
    .ack_ready(ack_ready), .logoff_ready(logoff_ready), .ack_valid(ack_valid),
    .ack_type(ack_type), .ack_accept(ack_accept), .ack_slot(ack_slot),
    .logoff_req(logoff_req), .access_enable(access_enable), .carrier_tx_en(carrier_tx_en),
    .perm_carrier(perm_carrier), .perm_slot(perm_slot));
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [32:0] seen, input logic [32:0] want);
    tests_run++;
    if (seen !== want) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  function automatic logic probe(input int sel);
    case (sel)
      0: probe = ack_valid;
      1: probe = access_enable;
      default: probe = carrier_tx_en;
    endcase
  endfunction
  // Bounded wait; running out counts as a mismatch and ends the run
  task automatic wait_until(input int sel, input logic val, input int bound);
    int n;
    n = 0;
    while (probe(sel) !== val) begin
      @(negedge ref_clk);
      n++;
      if (n > bound) begin
        chk(probe(sel), val);
        report_and_stop();
      end
    end
  endtask
  // Acknowledged element leaves in order of the assignments
  always @(posedge ref_clk) begin
    if (rst_n && ack_valid && ack_ready) begin
      if (exp_q.size() == 0) chk(33'h1, 33'h0);
      else chk({ack_type, ack_accept, ack_slot}, exp_q.pop_front());
    end
  end
  task automatic run(input logic [7:0] ta, input logic [7:0] tr, input logic c);
    logic [W-1:0] s;
    s = W'($random(seed));
    carrier_capable = c;
    exp_q.push_back({8'h05, c, s});
    u_cch_centre_model.send(ta, s);
    wait_until(0, 1'b1, 4);
    wait_until(0, 1'b0, 60);
    if (c) begin
      wait_until(1, 1'b0, 60);
      u_cch_centre_model.slot(~s);
      chk(carrier_tx_en, 1'b0);
      u_cch_centre_model.slot(s);
      wait_until(2, 1'b1, 3);
      chk(perm_carrier, ta == 8'h03);
      if (ta == 8'h03) chk(perm_slot, s);
      u_cch_centre_model.send(tr, s);
      // Permanent cases cut at the next slot start, the others by timeout
      if (ta == 8'h03) u_cch_centre_model.slot(~s);
      wait_until(2, 1'b0, RC + 4);
      chk(perm_carrier, 1'b0);
    end else chk(perm_carrier, 1'b0);
    k++;
    $display("test %0d done", k);
  endtask
  initial begin
    repeat (8) @(negedge ref_clk);
    rst_n = 1'b1;
    run(8'h00, 8'h01, 1'b1);
    run(8'h03, 8'h04, 1'b1);
    run(8'h00, 8'h01, 1'b0);
    run(8'h03, 8'h04, 1'b0);
    // Replacement, reserved, user codes and idle releases go unanswered
    for (int i = 0; i < 8; i++) begin
      u_cch_centre_model.send(codes[i], 24'h000123);
      repeat (3) @(negedge ref_clk);
      chk(ack_valid, 1'b0);
    end
    run(8'h00, 8'h01, 1'b1);
    chk(exp_q.size(), 33'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire
